//--- pkg/dscg_pkg.sv
// Package for the deep-sleep clock gating register block
// What this block does
// [RQ1] A set gating bit clocks its unit; a clear bit leaves it unclocked.
// [RQ2] Accesses to a unit whose clock is gated off answer with a bus fault.
// [RQ3] Reset clears every gating bit so all units start unclocked.
// [RQ4] Run, sleep or deep-sleep gating register selected by the current power mode.
// [RQ5] Sleep and deep-sleep settings apply only when automatic gating is selected.
// [RQ6] Comparators at 26:24, timers 19:16, I2C 12, serial ports 5:4, UARTs 2:0.
// [RQ7] Bit positions without a unit affect no clock.
// [RQ8] Reserved bits read zero and ignore writes; software preserves them.
package dscg_pkg;
  localparam logic [11:0] DSCG_OFFS_DEEP = 12'h124;
  localparam logic [11:0] DSCG_OFFS_RUN = 12'h104;
  localparam logic [11:0] DSCG_OFFS_SLEEP = 12'h114;
  localparam logic [11:0] DSCG_OFFS_CFG = 12'h060;
  localparam logic [31:0] DSCG_RESET_VAL = 32'h00000000;
  localparam logic [31:0] DSCG_VALID_MASK = 32'h070F1037;
  localparam int DSCG_ACG_BIT = 27;
  localparam int DSCG_NUM_UNITS = 32;
  localparam logic [1:0] DSCG_RESP_OKAY = 2'h0;
  localparam logic [1:0] DSCG_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DSCG_MODE_RUN,
    DSCG_MODE_SLEEP,
    DSCG_MODE_DEEP
  } dscg_mode_e;

  // Unit-side access request from the peripheral bus decoder
  typedef struct packed {
    logic valid;
    logic [4:0] unit;
  } dscg_periph_req_s;
endpackage

//--- hdl/dscg_top.sv
// Deep-sleep clock gating register block with AXI4-Lite slave
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module dscg_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dscg_pkg::dscg_mode_e power_mode,
  input wire dscg_pkg::dscg_periph_req_s periph_req,
  output logic periph_bus_fault,
  output logic [31:0] unit_clk_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [31:0] deep_sleep_clock_gate_1_reg, deep_sleep_clock_gate_1_next;
  logic [31:0] run_clock_gate_1_reg, run_clock_gate_1_next;
  logic [31:0] sleep_clock_gate_1_reg, sleep_clock_gate_1_next;
  logic auto_clock_gating_select_reg, auto_clock_gating_select_next;
  logic [11:0] awaddr_reg, awaddr_next;
  logic aw_held_reg, aw_held_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic w_held_reg, w_held_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] clk_en_reg, clk_en_next;
  logic fault_reg, fault_next;
  logic [31:0] wmask;
  logic [31:0] active_gate;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic arready_reg, arready_next;

  // Byte-lane mask; reserved bits are dropped at commit instead
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wstrb_reg[i]}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave and register updates
  always_comb begin
    awaddr_next = awaddr_reg;
    aw_held_next = aw_held_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    w_held_next = w_held_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    deep_sleep_clock_gate_1_next = deep_sleep_clock_gate_1_reg;
    run_clock_gate_1_next = run_clock_gate_1_reg;
    sleep_clock_gate_1_next = sleep_clock_gate_1_reg;
    auto_clock_gating_select_next = auto_clock_gating_select_reg;
    if (s_axi_awvalid && !aw_held_reg) begin
      awaddr_next = s_axi_awaddr;
      aw_held_next = 1'b1;
    end
    if (s_axi_wvalid && !w_held_reg) begin
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
      w_held_next = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // Address and data may arrive in either order
    // Both halves held and no response pending: commit one write
    if (aw_held_reg && w_held_reg && !bvalid_reg) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = dscg_pkg::DSCG_RESP_OKAY;
      if (awaddr_reg[11:2] == dscg_pkg::DSCG_OFFS_DEEP[11:2]) begin
        deep_sleep_clock_gate_1_next = ((deep_sleep_clock_gate_1_reg & ~wmask) | (wdata_reg & wmask))
          & dscg_pkg::DSCG_VALID_MASK; // see [RQ8]
      end else if (awaddr_reg[11:2] == dscg_pkg::DSCG_OFFS_RUN[11:2]) begin
        run_clock_gate_1_next = ((run_clock_gate_1_reg & ~wmask) | (wdata_reg & wmask))
          & dscg_pkg::DSCG_VALID_MASK;
      end else if (awaddr_reg[11:2] == dscg_pkg::DSCG_OFFS_SLEEP[11:2]) begin
        sleep_clock_gate_1_next = ((sleep_clock_gate_1_reg & ~wmask) | (wdata_reg & wmask))
          & dscg_pkg::DSCG_VALID_MASK;
      end else if (awaddr_reg[11:2] == dscg_pkg::DSCG_OFFS_CFG[11:2]) begin
        if (wstrb_reg[dscg_pkg::DSCG_ACG_BIT / 8]) begin
          auto_clock_gating_select_next = wdata_reg[dscg_pkg::DSCG_ACG_BIT];
        end
      end else begin
        bresp_next = dscg_pkg::DSCG_RESP_SLVERR;
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = dscg_pkg::DSCG_RESP_OKAY;
      rdata_next = '0;
      if (s_axi_araddr[11:2] == dscg_pkg::DSCG_OFFS_DEEP[11:2]) begin
        rdata_next = deep_sleep_clock_gate_1_reg;
      end else if (s_axi_araddr[11:2] == dscg_pkg::DSCG_OFFS_RUN[11:2]) begin
        rdata_next = run_clock_gate_1_reg;
      end else if (s_axi_araddr[11:2] == dscg_pkg::DSCG_OFFS_SLEEP[11:2]) begin
        rdata_next = sleep_clock_gate_1_reg;
      end else if (s_axi_araddr[11:2] == dscg_pkg::DSCG_OFFS_CFG[11:2]) begin
        rdata_next[dscg_pkg::DSCG_ACG_BIT] = auto_clock_gating_select_reg;
      end else begin
        rresp_next = dscg_pkg::DSCG_RESP_SLVERR;
      end
    end
    // Readies are flops of their own so no port leaves a gate
    awready_next = ~aw_held_next;
    wready_next = ~w_held_next;
    arready_next = ~rvalid_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate selection and unit fault
  always_comb begin
    active_gate = run_clock_gate_1_reg;
    // Without automatic gating the run settings hold in every mode
    if (auto_clock_gating_select_reg) begin // see [RQ5]
      case (power_mode) // see [RQ4]
        dscg_pkg::DSCG_MODE_SLEEP: active_gate = sleep_clock_gate_1_reg;
        dscg_pkg::DSCG_MODE_DEEP: active_gate = deep_sleep_clock_gate_1_reg;
        default: active_gate = run_clock_gate_1_reg;
      endcase
    end
  end

  generate
    for (genvar g = 0; g < dscg_pkg::DSCG_NUM_UNITS; g++) begin : gen_en
      // Unassigned positions stay masked to zero
      assign clk_en_next[g] = active_gate[g] & dscg_pkg::DSCG_VALID_MASK[g]; // see [RQ1] see [RQ6] see [RQ7]
    end
  endgenerate

  // Fault one cycle after a request to an unclocked unit
  // Reserved positions never enable, so requests to them always fault
  assign fault_next = periph_req.valid & ~clk_en_reg[periph_req.unit]; // see [RQ2]

  always_ff @(posedge clk) begin
    if (reset) begin
      deep_sleep_clock_gate_1_reg <= dscg_pkg::DSCG_RESET_VAL; // see [RQ3]
      run_clock_gate_1_reg <= dscg_pkg::DSCG_RESET_VAL;
      sleep_clock_gate_1_reg <= dscg_pkg::DSCG_RESET_VAL;
      auto_clock_gating_select_reg <= 1'b0;
      awaddr_reg <= '0;
      aw_held_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= dscg_pkg::DSCG_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= dscg_pkg::DSCG_RESP_OKAY;
      rdata_reg <= '0;
      clk_en_reg <= dscg_pkg::DSCG_RESET_VAL;
      fault_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      arready_reg <= 1'b1;
    end else begin
      deep_sleep_clock_gate_1_reg <= deep_sleep_clock_gate_1_next;
      run_clock_gate_1_reg <= run_clock_gate_1_next;
      sleep_clock_gate_1_reg <= sleep_clock_gate_1_next;
      auto_clock_gating_select_reg <= auto_clock_gating_select_next;
      awaddr_reg <= awaddr_next;
      aw_held_reg <= aw_held_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      w_held_reg <= w_held_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      clk_en_reg <= clk_en_next;
      fault_reg <= fault_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      arready_reg <= arready_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port outputs, each straight from a flop
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign unit_clk_en = clk_en_reg;
  assign periph_bus_fault = fault_reg;

endmodule
`default_nettype wire

//--- verification/dscg_top_sva.sv
// Concurrent checks on the deep-sleep clock gating block ports
`timescale 1ns/100ps
`default_nettype none
module dscg_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire dscg_pkg::dscg_mode_e power_mode,
  input wire dscg_pkg::dscg_periph_req_s periph_req,
  input wire logic periph_bus_fault,
  input wire logic [31:0] unit_clk_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Gate bits plus the auto-select bit of the config word
  localparam logic [31:0] READ_MASK = dscg_pkg::DSCG_VALID_MASK | (32'h1 << dscg_pkg::DSCG_ACG_BIT);
  rsv_clk_off_a: assert property ((unit_clk_en & ~dscg_pkg::DSCG_VALID_MASK) == 32'h0)
    else $error("enable set on a position with no unit");
  gated_fault_a: assert property (periph_req.valid && !unit_clk_en[periph_req.unit] |=> periph_bus_fault)
    else $error("access to gated unit not faulted");
  clocked_ok_a: assert property (periph_req.valid && unit_clk_en[periph_req.unit] |=> !periph_bus_fault)
    else $error("access to clocked unit faulted");
  fault_cause_a: assert property (periph_bus_fault |->
    $past(periph_req.valid) && !$past(unit_clk_en[periph_req.unit])) else $error("fault without gated request");
  reset_clear_a: assert property (disable iff (1'b0) reset |=> unit_clk_en == 32'h0 && !periph_bus_fault)
    else $error("enables not cleared by reset");
  rsv_read_zero_a: assert property (s_axi_rvalid |-> (s_axi_rdata & ~READ_MASK) == 32'h0)
    else $error("reserved bits read nonzero");
  err_read_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  // Slack of one cycle either way: enable is registered behind the select
  en_change_a: assert property (unit_clk_en != $past(unit_clk_en) |-> s_axi_bvalid || $past(s_axi_bvalid)
    || power_mode != $past(power_mode) || $past(power_mode) != $past(power_mode, 2)) else $error("enable moved alone");
  cover property (periph_bus_fault);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (power_mode == dscg_pkg::DSCG_MODE_DEEP && unit_clk_en != 32'h0);
endmodule
bind dscg_top dscg_chk i_chk (.clk, .reset, .s_axi_bvalid, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .power_mode, .periph_req, .periph_bus_fault, .unit_clk_en);
`default_nettype wire

//--- verification/dscg_top_tb_top.sv
// Self-checking bench for the deep-sleep clock gating block
`timescale 1ns/100ps
`default_nettype none
module dscg_top_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, periph_bus_fault;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, unit_clk_en;
  dscg_pkg::dscg_mode_e power_mode = dscg_pkg::DSCG_MODE_RUN;
  dscg_pkg::dscg_periph_req_s periph_req = 6'h00;
  int mismatches = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  dscg_top i_dut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_mode, .periph_req,
    .periph_bus_fault, .unit_clk_en);
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Ready is looked at mid-cycle, so the edge that takes it is never raced
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw, ta, tw;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge clk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge clk); while (!s_axi_bvalid);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (!s_axi_rvalid);
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic mode(input dscg_pkg::dscg_mode_e m, input logic [31:0] e);
    @(posedge clk);
    power_mode <= m;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("unit_clk_en", e, unit_clk_en);
  endtask
  task automatic req(input logic [4:0] u, input logic ef);
    @(posedge clk);
    periph_req <= {1'b1, u};
    @(posedge clk);
    periph_req <= {1'b0, u};
    @(negedge clk);
    chk("periph_bus_fault", {31'h0, ef}, {31'h0, periph_bus_fault});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    mode(dscg_pkg::DSCG_MODE_RUN, 32'h0);
    rd(12'h124, 32'h0, 2'h0);
    rd(12'h060, 32'h0, 2'h0);
    $display("test reset done");
    wr(12'h124, 32'hFFFFFFFF, 2'h0);
    rd(12'h124, 32'h070F1037, 2'h0);
    wr(12'h200, 32'hFFFFFFFF, 2'h2);
    rd(12'h200, 32'h0, 2'h2);
    for (int i = 0; i < 32; i++) begin
      wr(12'h104, 32'h1 << i, 2'h0);
      mode(dscg_pkg::DSCG_MODE_RUN, (32'h1 << i) & 32'h070F1037);
    end
    $display("test layout done");
    wr(12'h104, 32'h00001010, 2'h0);
    wr(12'h114, 32'h01000005, 2'h0);
    mode(dscg_pkg::DSCG_MODE_DEEP, 32'h00001010);
    wr(12'h060, 32'h08000000, 2'h0);
    mode(dscg_pkg::DSCG_MODE_DEEP, 32'h070F1037);
    mode(dscg_pkg::DSCG_MODE_SLEEP, 32'h01000005);
    mode(dscg_pkg::DSCG_MODE_RUN, 32'h00001010);
    $display("test modes done");
    req(5'd12, 1'b0);
    req(5'd0, 1'b1);
    req(5'd3, 1'b1);
    $display("test faults done");
    // Reset in mid-run must drop every enable written above
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    mode(dscg_pkg::DSCG_MODE_RUN, 32'h0);
    rd(12'h124, 32'h0, 2'h0);
    rd(12'h060, 32'h0, 2'h0);
    $display("test mid-run reset done");
    summarize();
  end
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
